// *** hdl/kpi_pkg.sv ***
// kpi_pkg: shared constants and types of the key pin interrupt unit
package kpi_pkg;

    // widths of the register port and of the pin group
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PIN_COUNT = 4;
    localparam int EV_W = 2;

    // register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PIN_ENABLE = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h04;

    // field positions of key_status_control
    localparam int SC_FLAG_BIT = 3;
    localparam int SC_ACK_BIT = 2;
    localparam int SC_IE_BIT = 1;
    localparam int SC_MODE_BIT = 0;

    // field positions of the interrupt status and mask registers
    localparam int IST_EVENT_BIT = 0;
    localparam int IST_WAKE_BIT = 1;

    // reset values
    localparam logic [PIN_COUNT-1:0] RST_PIN_ENABLE = 4'h0;
    localparam logic [PIN_COUNT-1:0] RST_POLARITY = 4'h0;
    localparam logic RST_IRQ_ENABLE = 1'b0;
    localparam logic RST_EVENT_FLAG = 1'b0;
    localparam logic [EV_W-1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [EV_W-1:0] RST_IRQ_STATUS = 2'h0;
    localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;

    // detection mode: first value is edge-only, second edge plus level
    typedef enum logic {
        KPI_EDGE_ONLY,
        KPI_EDGE_LEVEL
    } kpi_mode_t;

endpackage

// *** hdl/kpi_pin_detect.sv ***
// kpi_pin_detect: per-pin sampling, polarity and edge detection
`timescale 1ns/1ps
module kpi_pin_detect #(
    parameter int NUM_PINS = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sync_clr,
    input wire logic [NUM_PINS-1:0] pins,
    input wire logic [NUM_PINS-1:0] polarity,
    output logic [NUM_PINS-1:0] edge_hit,
    output logic [NUM_PINS-1:0] level_hit
);

    // a pin is asserted at low level for polarity 0, at high level for polarity 1
    logic [NUM_PINS-1:0] asserted;
    // asserted state seen on the previous bus cycle
    logic [NUM_PINS-1:0] prev_asserted_q;

    assign asserted = ~(pins ^ polarity);

    // previous sample starts as asserted so a pin must first sit at reset level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_asserted_q <= '1;
        end else if (sync_clr) begin
            prev_asserted_q <= '1;
        end else begin
            prev_asserted_q <= asserted;
        end
    end

    // edge: not asserted last cycle, asserted now
    assign edge_hit = asserted & ~prev_asserted_q;
    assign level_hit = asserted;

endmodule

// *** hdl/kpi_irq_status.sv ***
// kpi_irq_status: sticky event status, mask and level interrupt output
`timescale 1ns/1ps
module kpi_irq_status #(
    parameter int EV_W = 2
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sync_clr,
    input wire logic [EV_W-1:0] events,
    input wire logic rd_clear,
    input wire logic mask_wr,
    input wire logic [EV_W-1:0] mask_wdata,
    output logic [EV_W-1:0] status,
    output logic [EV_W-1:0] mask,
    output logic irq
);

    logic [EV_W-1:0] status_d;
    logic [EV_W-1:0] mask_d;

    // an event in the clearing read cycle survives: set wins over clear
    always_comb begin
        status_d = (status & ~{EV_W{rd_clear}}) | events;
        mask_d = mask_wr ? mask_wdata : mask;
    end

    // status, mask and the registered interrupt level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status <= kpi_pkg::RST_IRQ_STATUS;
            mask <= kpi_pkg::RST_IRQ_MASK;
            irq <= 1'b0;
        end else if (sync_clr) begin
            status <= kpi_pkg::RST_IRQ_STATUS;
            mask <= kpi_pkg::RST_IRQ_MASK;
            irq <= 1'b0;
        end else begin
            status <= status_d;
            mask <= mask_d;
            irq <= |(status_d & mask_d);
        end
    end

    property p_irq_level;
        @(posedge ref_clk) disable iff (!arst_n) irq == |(status & mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level not status and mask");

endmodule

// *** hdl/kpi_top.sv ***
// kpi_top: key pin interrupt unit with register port and wake request
//
// Notes on behaviour
// - four key pins, disabled pins are ignored
// - falling, rising, falling+low or rising+high trigger
// - retain stop mode keeps detecting, wakes processor
// - power-off stop disables unit, registers reset
// - debug halt does not stop detection
// - control bits seven to four read zero
// - event flag read only, writes ignored
// - acknowledge bit write one clears, reads zero
// - interrupt enable gates the interrupt request
// - mode bit picks edge-only or edge+level
// - pin enable bits select active pins
// - polarity bits pick falling/low or rising/high
// - edge is two successive bus-cycle samples
// - valid edge or level sets the flag
// - acknowledge clears flag unless edge+level mode and level still asserted
// - polarity picks pullup or pulldown resistor
`timescale 1ns/1ps
module kpi_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [kpi_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [kpi_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [kpi_pkg::DATA_W-1:0] bus_rdata,
    input wire logic [kpi_pkg::PIN_COUNT-1:0] key_input_pins,
    input wire logic stop_retain_mode,
    input wire logic stop_poweroff_mode,
    input wire logic [kpi_pkg::PIN_COUNT-1:0] port_a_pull_enable,
    output logic key_irq_req,
    output logic wake_req,
    output logic irq,
    output logic [kpi_pkg::PIN_COUNT-1:0] pull_up_en,
    output logic [kpi_pkg::PIN_COUNT-1:0] pull_down_en
);

    // address match, shared by every strobe decode
    function automatic logic addr_hit(
        input logic [kpi_pkg::ADDR_W-1:0] addr,
        input logic [kpi_pkg::ADDR_W-1:0] ofs
    );
        addr_hit = (addr == ofs);
    endfunction

    // control state
    logic key_event_flag_q; // event flag, bit 3 of status/control
    logic key_irq_enable_q; // interrupt enable, bit 1
    kpi_pkg::kpi_mode_t key_detect_mode_q; // detection mode, bit 0
    logic [kpi_pkg::PIN_COUNT-1:0] key_pin_enable_q; // pin enable register
    logic [kpi_pkg::PIN_COUNT-1:0] key_polarity_q; // polarity select register
    logic key_irq_req_q; // request to the processor
    logic wake_req_q; // wake request out of retain stop
    logic [kpi_pkg::DATA_W-1:0] bus_rdata_q; // read data, one cycle after strobe
    logic [kpi_pkg::PIN_COUNT-1:0] pull_up_q;
    logic [kpi_pkg::PIN_COUNT-1:0] pull_down_q;

    // decoded strobes
    logic wr_sc;
    logic wr_pe;
    logic wr_pol;
    logic wr_msk;
    logic rd_ist;
    logic ack_wr;

    // detector results
    logic [kpi_pkg::PIN_COUNT-1:0] edge_hit;
    logic [kpi_pkg::PIN_COUNT-1:0] level_hit;
    logic set_term; // some enabled pin triggers this cycle
    logic flag_d;
    logic wake_d;
    logic [kpi_pkg::EV_W-1:0] irq_events;
    logic [kpi_pkg::EV_W-1:0] irq_status;
    logic [kpi_pkg::EV_W-1:0] irq_mask;
    logic irq_w;
    logic [kpi_pkg::DATA_W-1:0] rd_mux;

    // power-off stop acts as a held synchronous reset, so on wake all but the pull resistor selects and the read data flop is at reset
    logic poweroff;
    assign poweroff = stop_poweroff_mode;

    // strobe decode; a write never waits, it lands on this edge
    always_comb begin
        wr_sc = bus_wr && addr_hit(bus_addr, kpi_pkg::OFS_STATUS_CONTROL);
        wr_pe = bus_wr && addr_hit(bus_addr, kpi_pkg::OFS_PIN_ENABLE);
        wr_pol = bus_wr && addr_hit(bus_addr, kpi_pkg::OFS_POLARITY);
        wr_msk = bus_wr && addr_hit(bus_addr, kpi_pkg::OFS_IRQ_MASK);
        rd_ist = bus_rd && addr_hit(bus_addr, kpi_pkg::OFS_IRQ_STATUS);
        ack_wr = wr_sc && bus_wdata[kpi_pkg::SC_ACK_BIT];
    end

    // pin sampling and edge detection
    kpi_pin_detect #(
        .NUM_PINS(kpi_pkg::PIN_COUNT)
    ) u_detect (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sync_clr(poweroff),
        .pins(key_input_pins),
        .polarity(key_polarity_q),
        .edge_hit(edge_hit),
        .level_hit(level_hit)
    );

    // trigger term: edges always, levels only in edge+level mode; masked by enables
    // no debug-halt qualifier exists here, so detection runs on while halted
    always_comb begin
        set_term = |(edge_hit & key_pin_enable_q);
        if (key_detect_mode_q == kpi_pkg::KPI_EDGE_LEVEL) begin
            set_term = set_term | (|(level_hit & key_pin_enable_q));
        end
    end

    // next flag: set wins over the acknowledge, which also keeps a held level set
    always_comb begin
        if (poweroff) begin
            flag_d = kpi_pkg::RST_EVENT_FLAG;
        end else if (set_term) begin
            flag_d = 1'b1;
        end else if (ack_wr) begin
            flag_d = 1'b0;
        end else begin
            flag_d = key_event_flag_q;
        end
    end

    // event flag register; bit 3 of a write is never looked at
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            key_event_flag_q <= kpi_pkg::RST_EVENT_FLAG;
        end else begin
            key_event_flag_q <= flag_d;
        end
    end

    // interrupt enable and detection mode fields
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            key_irq_enable_q <= kpi_pkg::RST_IRQ_ENABLE;
            key_detect_mode_q <= kpi_pkg::KPI_EDGE_ONLY;
        end else if (poweroff) begin
            key_irq_enable_q <= kpi_pkg::RST_IRQ_ENABLE;
            key_detect_mode_q <= kpi_pkg::KPI_EDGE_ONLY;
        end else if (wr_sc) begin
            key_irq_enable_q <= bus_wdata[kpi_pkg::SC_IE_BIT];
            key_detect_mode_q <= kpi_pkg::kpi_mode_t'(bus_wdata[kpi_pkg::SC_MODE_BIT]);
        end
    end

    // pin enable and polarity registers; upper write bits are dropped
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            key_pin_enable_q <= kpi_pkg::RST_PIN_ENABLE;
            key_polarity_q <= kpi_pkg::RST_POLARITY;
        end else if (poweroff) begin
            key_pin_enable_q <= kpi_pkg::RST_PIN_ENABLE;
            key_polarity_q <= kpi_pkg::RST_POLARITY;
        end else begin
            if (wr_pe) begin
                key_pin_enable_q <= bus_wdata[kpi_pkg::PIN_COUNT-1:0];
            end
            if (wr_pol) begin
                key_polarity_q <= bus_wdata[kpi_pkg::PIN_COUNT-1:0];
            end
        end
    end

    // wake: the clock is assumed to keep running in retain stop, slow as it may be;
    // a fully stopped clock would need an unclocked path that this block lacks
    always_comb begin
        wake_d = !poweroff && stop_retain_mode && key_irq_enable_q
                 && (key_event_flag_q || set_term);
    end

    // request outputs, one flop each
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            key_irq_req_q <= 1'b0;
            wake_req_q <= 1'b0;
        end else begin
            key_irq_req_q <= !poweroff && key_event_flag_q && key_irq_enable_q;
            wake_req_q <= wake_d;
        end
    end

    // events for the sticky status: flag rising and wake rising
    always_comb begin
        irq_events = '0;
        irq_events[kpi_pkg::IST_EVENT_BIT] = !poweroff && set_term && !key_event_flag_q;
        irq_events[kpi_pkg::IST_WAKE_BIT] = wake_d && !wake_req_q;
    end

    // sticky status, clear on read, mask and interrupt level
    kpi_irq_status #(
        .EV_W(kpi_pkg::EV_W)
    ) u_irq (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sync_clr(poweroff),
        .events(irq_events),
        .rd_clear(rd_ist),
        .mask_wr(wr_msk),
        .mask_wdata(bus_wdata[kpi_pkg::EV_W-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq_w)
    );

    // read mux; unmapped offsets and unused bits read zero
    always_comb begin
        rd_mux = kpi_pkg::RST_RDATA;
        if (addr_hit(bus_addr, kpi_pkg::OFS_STATUS_CONTROL)) begin
            rd_mux[kpi_pkg::SC_FLAG_BIT] = key_event_flag_q;
            rd_mux[kpi_pkg::SC_ACK_BIT] = 1'b0;
            rd_mux[kpi_pkg::SC_IE_BIT] = key_irq_enable_q;
            rd_mux[kpi_pkg::SC_MODE_BIT] = (key_detect_mode_q == kpi_pkg::KPI_EDGE_LEVEL);
        end else if (addr_hit(bus_addr, kpi_pkg::OFS_PIN_ENABLE)) begin
            rd_mux[kpi_pkg::PIN_COUNT-1:0] = key_pin_enable_q;
        end else if (addr_hit(bus_addr, kpi_pkg::OFS_POLARITY)) begin
            rd_mux[kpi_pkg::PIN_COUNT-1:0] = key_polarity_q;
        end else if (addr_hit(bus_addr, kpi_pkg::OFS_IRQ_STATUS)) begin
            rd_mux[kpi_pkg::EV_W-1:0] = irq_status;
        end else if (addr_hit(bus_addr, kpi_pkg::OFS_IRQ_MASK)) begin
            rd_mux[kpi_pkg::EV_W-1:0] = irq_mask;
        end
    end

    // read data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata_q <= kpi_pkg::RST_RDATA;
        end else if (bus_rd) begin
            bus_rdata_q <= rd_mux;
        end else begin
            bus_rdata_q <= kpi_pkg::RST_RDATA;
        end
    end

    // resistor selection: only where the port enables a resistor
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pull_up_q <= '0;
            pull_down_q <= '0;
        end else begin
            pull_up_q <= port_a_pull_enable & key_polarity_q;
            pull_down_q <= port_a_pull_enable & ~key_polarity_q;
        end
    end

    // outputs straight from flops
    assign bus_rdata = bus_rdata_q;
    assign key_irq_req = key_irq_req_q;
    assign wake_req = wake_req_q;
    assign irq = irq_w;
    assign pull_up_en = pull_up_q;
    assign pull_down_en = pull_down_q;

    // checks on the behaviour above
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    property p_disabled_ignored;
        (key_pin_enable_q == 4'h0) && !key_event_flag_q |=> !key_event_flag_q;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored) else $error("flag set by disabled pins");

    property p_edge_sets;
        (|(edge_hit & key_pin_enable_q)) && !poweroff |=> key_event_flag_q;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("enabled edge did not set flag");

    // a held asserted level alone must set the flag in edge+level mode
    property p_level_sets;
        (key_detect_mode_q == kpi_pkg::KPI_EDGE_LEVEL) && (|(level_hit & key_pin_enable_q))
            && !poweroff |=> key_event_flag_q;
    endproperty
    a_level_sets: assert property (p_level_sets) else $error("held level did not set flag");

    property p_level_holds;
        ack_wr && !poweroff && (key_detect_mode_q == kpi_pkg::KPI_EDGE_LEVEL)
            && (|(level_hit & key_pin_enable_q)) |=> key_event_flag_q;
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("ack cleared a held level");

    property p_ack_clears;
        ack_wr && !set_term |=> !key_event_flag_q;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear flag");

    property p_flag_write_ignored;
        wr_sc && !ack_wr && !poweroff |=> key_event_flag_q == ($past(key_event_flag_q)
            || $past(set_term));
    endproperty
    a_flag_write_ignored: assert property (p_flag_write_ignored) else $error("write moved flag");

    property p_irq_gate;
        !key_irq_enable_q |=> !key_irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request with enable clear");

    property p_irq_raise;
        key_event_flag_q && key_irq_enable_q && !poweroff |=> key_irq_req;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("no request for set flag");

    property p_read_zero;
        bus_rd && addr_hit(bus_addr, kpi_pkg::OFS_STATUS_CONTROL)
            |=> (bus_rdata[7:4] == 4'h0) && !bus_rdata[kpi_pkg::SC_ACK_BIT];
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("unused or ack bits read one");

    property p_poweroff_reset;
        stop_poweroff_mode |=> (key_pin_enable_q == 4'h0) && !key_irq_enable_q
            && !key_event_flag_q ##1 !key_irq_req && !wake_req;
    endproperty
    a_poweroff_reset: assert property (p_poweroff_reset) else $error("power-off left state");

    property p_wake;
        stop_retain_mode && key_irq_enable_q && key_event_flag_q && !poweroff |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake in retain stop");

    // never both resistors, and the pullup follows enable and polarity one cycle late
    property p_pull;
        1'b1 |=> ((pull_up_en & pull_down_en) == 4'h0)
            && (pull_up_en == ($past(port_a_pull_enable) & $past(key_polarity_q)));
    endproperty
    a_pull: assert property (p_pull) else $error("pullup and pulldown together");

    property p_edge_mode_no_level;
        (key_detect_mode_q == kpi_pkg::KPI_EDGE_ONLY) && !key_event_flag_q
            && !(|(edge_hit & key_pin_enable_q)) |=> !key_event_flag_q;
    endproperty
    a_edge_mode_no_level: assert property (p_edge_mode_no_level) else $error("level in edge mode");

    c_edge_flag: cover property (!key_event_flag_q ##1 key_event_flag_q ##1 key_irq_req);
    c_level_ack: cover property (ack_wr && set_term
        && key_detect_mode_q == kpi_pkg::KPI_EDGE_LEVEL);
    c_wake: cover property (stop_retain_mode ##1 wake_req);
    c_irq_out: cover property (!irq ##1 irq);

endmodule

// *** dv/kpi_key_model.sv ***
// kpi_key_model: behavioural key switches with pull resistors on the pins
`timescale 1ns/1ps
module kpi_key_model (
    input wire logic ref_clk,
    input wire logic [kpi_pkg::PIN_COUNT-1:0] sw_closed,
    input wire logic [kpi_pkg::PIN_COUNT-1:0] sw_level,
    input wire logic sw_slow,
    input wire logic [kpi_pkg::PIN_COUNT-1:0] pull_up_en,
    input wire logic [kpi_pkg::PIN_COUNT-1:0] pull_down_en,
    output logic [kpi_pkg::PIN_COUNT-1:0] key_input_pins
);
    // one-cycle late copy of the commanded levels, for a slow source
    logic [kpi_pkg::PIN_COUNT-1:0] lvl_q;

    // delay stage of the slow source
    always_ff @(posedge ref_clk) begin
        lvl_q <= sw_level;
    end

    // pin level: closed switch wins, else the resistor, else a floating line
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < kpi_pkg::PIN_COUNT; i++) begin
            if (sw_closed[i]) begin
                key_input_pins[i] <= sw_slow ? lvl_q[i] : sw_level[i];
            end else if (pull_up_en[i]) begin
                key_input_pins[i] <= 1'b1;
            end else if (pull_down_en[i]) begin
                key_input_pins[i] <= 1'b0;
            end else begin
                // floating: no stable value, so toggle every cycle
                key_input_pins[i] <= ~key_input_pins[i];
            end
        end
    end
endmodule

// *** dv/kpi_top_tb.sv ***
// kpi_top_tb: self-checking bench of the key pin interrupt unit
`timescale 1ns/1ps
module kpi_top_tb;
    localparam logic [7:0] SC = kpi_pkg::OFS_STATUS_CONTROL;
    localparam logic [7:0] PE = kpi_pkg::OFS_PIN_ENABLE;
    localparam logic [7:0] PO = kpi_pkg::OFS_POLARITY;
    localparam logic [7:0] IS = kpi_pkg::OFS_IRQ_STATUS;
    localparam logic [7:0] IM = kpi_pkg::OFS_IRQ_MASK;
    localparam logic [7:0] MAP [5] = '{SC, PE, PO, IS, IM};
    localparam logic [7:0] FLG = 8'h01 << kpi_pkg::SC_FLAG_BIT;
    localparam logic [7:0] ACK = 8'h01 << kpi_pkg::SC_ACK_BIT;
    localparam logic [7:0] IE = 8'h01 << kpi_pkg::SC_IE_BIT;
    localparam logic [7:0] MD = 8'h01 << kpi_pkg::SC_MODE_BIT;
    logic ref_clk, arst_n, bus_wr, bus_rd, rd_q, sw_slow;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, rv;
    logic stop_retain_mode, stop_poweroff_mode, key_irq_req, wake_req, irq;
    logic [3:0] key_input_pins, port_a_pull_enable, pull_up_en, pull_down_en;
    logic [3:0] sw_closed, sw_level, pv;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int err_count, check_count, cyc;

    kpi_top i_kpi_top (.ref_clk(ref_clk), .arst_n(arst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .key_input_pins(key_input_pins), .stop_retain_mode(stop_retain_mode),
        .stop_poweroff_mode(stop_poweroff_mode), .port_a_pull_enable(port_a_pull_enable),
        .key_irq_req(key_irq_req), .wake_req(wake_req), .irq(irq),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));
    kpi_key_model i_kpi_key_model (.ref_clk(ref_clk), .sw_closed(sw_closed),
        .sw_level(sw_level), .sw_slow(sw_slow), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .key_input_pins(key_input_pins));

    // free-running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // shared compare: counts every check, reports a mismatch at once
    task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
        check_count++;
        if (got !== e) begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, m, got, e);
        end
    endtask

    // closing report, the only place the run ends
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe, else zero
    always @(posedge ref_clk) rd_q <= bus_rd;
    always @(negedge ref_clk) begin
        if (rd_q === 1'b1) begin
            chk(bus_rdata, exp_q.pop_front(), "read data");
        end else if (bus_rdata !== 8'h00) begin
            chk(bus_rdata, 8'h00, "idle read data");
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    // one-cycle read strobe; the expectation is noted before the request
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
    endtask

    // set the switch levels, then let n cycles pass and settle mid-cycle
    task automatic pins(input logic [3:0] v, input int n);
        @(posedge ref_clk);
        sw_level <= v;
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    initial begin
        {bus_wr, bus_rd, stop_retain_mode, stop_poweroff_mode, sw_slow} = 5'h00;
        {bus_addr, bus_wdata, cyc, err_count, check_count} = '0;
        {port_a_pull_enable, sw_closed, sw_level} = {4'h0, 4'hf, 4'h0};
        arst_n = 1'b0;
        void'($urandom(11));
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        // reset values, unmapped place and access kinds
        foreach (MAP[i]) rd(MAP[i], 8'h00);
        rd(8'h1f, 8'h00);
        rv = 8'($urandom());
        wr(PE, rv);
        rd(PE, rv & 8'h0f);
        wr(PE, 8'h00);
        rv = 8'($urandom());
        wr(PO, rv);
        rd(PO, rv & 8'h0f);
        wr(SC, 8'hf8);
        rd(SC, 8'h00);
        wr(SC, 8'h07);
        rd(SC, IE | MD);
        wr(SC, 8'h00);
        $display("test registers done");
        // every pin in both polarities, with disabled pins moving meanwhile
        for (int p = 0; p < 4; p++) begin
            for (int pol = 0; pol < 2; pol++) begin
                sw_slow <= pol[0];
                wr(PE, 8'h00);
                wr(PO, {4'h0, {4{pol[0]}}});
                pins({4{~pol[0]}}, 4);
                wr(PE, 8'h01 << p);
                wr(SC, ACK);
                rd(IS, 8'h00);
                pins({4{~pol[0]}} ^ ~(4'h1 << p), 4);
                rd(SC, 8'h00);
                pins({4{pol[0]}}, 4);
                rd(SC, FLG);
                rd(IS, 8'h01);
                rd(IS, 8'h00);
            end
        end
        $display("test edges done");
        // pin 3 rising/high still asserted: edge mode clears, level mode holds
        wr(SC, ACK);
        rd(SC, 8'h00);
        wr(SC, ACK | MD);
        rd(SC, FLG | MD);
        wr(SC, ACK | MD);
        rd(SC, FLG | MD);
        pins(4'h0, 3);
        wr(SC, ACK | MD);
        rd(SC, MD);
        $display("test level done");
        // interrupt enable gating and the masked level interrupt
        wr(IM, 8'h01);
        wr(SC, IE | ACK);
        rd(IS, 8'h01);
        pins(4'h0, 2);
        chk({7'h0, key_irq_req}, 8'h00, "request idle");
        pins(4'hf, 4);
        chk({7'h0, key_irq_req}, 8'h01, "request raised");
        chk({7'h0, irq}, 8'h01, "irq raised");
        wr(SC, 8'h00);
        pins(4'hf, 2);
        chk({7'h0, key_irq_req}, 8'h00, "request gated");
        rd(SC, FLG);
        rd(IS, 8'h01);
        pins(4'hf, 2);
        chk({7'h0, irq}, 8'h00, "irq cleared by read");
        $display("test interrupt done");
        // wake from retained stop
        pins(4'h0, 2);
        wr(SC, ACK);
        rd(IS, 8'h00);
        stop_retain_mode <= 1'b1;
        wr(SC, IE);
        pins(4'h0, 2);
        chk({7'h0, wake_req}, 8'h00, "wake idle");
        pins(4'hf, 4);
        chk({7'h0, wake_req}, 8'h01, "wake raised");
        rd(IS, 8'h03);
        stop_retain_mode <= 1'b0;
        $display("test retain stop done");
        // resistor choice, then power-off stop clears every mapped register
        pv = 4'($urandom());
        port_a_pull_enable <= pv;
        rv = 8'($urandom()) & 8'h0f;
        wr(PO, rv);
        pins(4'hf, 3);
        chk({4'h0, pull_up_en}, {4'h0, pv & rv[3:0]}, "pull up");
        chk({4'h0, pull_down_en}, {4'h0, pv & ~rv[3:0]}, "pull down");
        @(posedge ref_clk);
        stop_poweroff_mode <= 1'b1;
        pins(4'hf, 2);
        @(posedge ref_clk);
        stop_poweroff_mode <= 1'b0;
        foreach (MAP[i]) rd(MAP[i], 8'h00);
        pins(4'hf, 2);
        chk({7'h0, key_irq_req}, 8'h00, "request after power-off");
        $display("test power-off done");
        give_verdict();
    end
endmodule
